// [common/aso_pkg.sv]
package aso_pkg;
   // ***********************************************************************
   // Timing of the self-clocked output cycle.
   // ***********************************************************************
   localparam int CLK_NS = 20;
   // Power-on reset window; the mode strap is sampled when it closes.
   localparam int POR_TIME_NS = 1000000;
   localparam int POR_CYC = (POR_TIME_NS + CLK_NS - 1) / CLK_NS;
   // Half of the internal serial clock period, also the least sleep time.
   localparam int SCK_HALF_NS = 80;
   localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;

   // ***********************************************************************
   // Frame layout.
   // ***********************************************************************
   localparam int FRAME_BITS = 32;
   localparam logic [5:0] FRAME_LAST = 6'h20;
   localparam logic [5:0] FRAME_FIRST = 6'h01;
   // The first bit of the frame is the pending flag, which is low once sleep begins.
   localparam logic PEND_IDLE = 1'b0;

   typedef enum logic [2:0] {
      ASO_POR = 3'h0,
      ASO_CONV = 3'h1,
      ASO_SLEEP = 3'h3,
      ASO_HI = 3'h2,
      ASO_LO = 3'h6,
      ASO_EXT = 3'h4
   } aso_state_t;
endpackage

// [design/aso_sync.sv]
`timescale 1ns/1ns
module aso_sync #(
   parameter logic INIT = 1'b1
) (
   input wire logic clk,   // System clock.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic d,     // Asynchronous level.
   output logic q          // Level in the clk domain.
);
   logic meta_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_q <= INIT;
         q <= INIT;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// [design/aso_serial_out.sv]
`timescale 1ns/1ns
// Functional notes
// - Serial clock mode is fixed when power-on reset ends, about 1ms in.
// - Weak pull-up on clock pin during power-on reset; high pin selects self-clocked mode.
// - Clock pin held low at reset end selects external clock mode instead.
// - During conversion both clock and data are held high.
// - Conversion end drives clock and data low, entering sleep.
// - Sleep lasts at least half a clock period, then output starts unprompted.
// - Clock is generated internally; frame spans first to 32nd rising edge.
// - Data changes on each falling clock edge, one bit per period.
// - After 32nd rise data goes high; clock stays high through conversion.
// - Pending flag is 1 while converting and 0 once asleep.
module aso_serial_out #(
   parameter int POR_CYCLES = aso_pkg::POR_CYC,
   parameter int HALF_CYCLES = aso_pkg::SCK_HALF_CYC,
   parameter int DATA_W = aso_pkg::FRAME_BITS - 1
) (
   input wire logic clk,                     // System clock, 50 MHz.
   input wire logic rst_n,                   // Synchronous reset, active low.
   input wire logic sck_i,                   // Serial clock pin level.
   output logic sck_o,                       // Serial clock pin drive value.
   output logic sck_oe,                      // Serial clock pin drive enable.
   output logic sck_pu_en,                   // Weak pull-up on the clock pin.
   output logic sdo_o,                       // Serial data output.
   input wire logic conv_done,               // Converter core finished, one pulse.
   input wire logic [DATA_W-1:0] conv_data,  // Result word, valid with conv_done.
   output logic conv_start,                  // Start of a conversion, one pulse.
   output logic conv_pending,                // Conversion in progress.
   output logic ext_mode                     // External clock mode was selected.
);
   import aso_pkg::*;

   localparam int TW = $clog2(POR_CYCLES + 1);
   localparam logic [TW-1:0] POR_LOAD = TW'(POR_CYCLES - 1);
   localparam logic [TW-1:0] HALF_LOAD = TW'(HALF_CYCLES - 1);
   localparam logic [TW-1:0] T_ZERO = '0;

   if (DATA_W != FRAME_BITS - 1 || HALF_CYCLES < 1 || POR_CYCLES <= HALF_CYCLES) begin : g_chk
      $error("aso_serial_out: unsupported parameter values");
   end

   // ***********************************************************************
   // Pin sampling and state.
   // ***********************************************************************
   logic sck_s;
   aso_state_t st_q, st_d;
   logic [TW-1:0] cnt_q, cnt_d;
   logic [5:0] bit_q, bit_d;
   logic [FRAME_BITS-1:0] sh_q, sh_d;
   logic sck_q, oe_q, pu_q, sdo_q, start_q, pend_q, ext_q;

   aso_sync #(.INIT(1'b1)) u_sck_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(sck_i),
      .q(sck_s)
   );

   wire tdone = (cnt_q == T_ZERO);
   wire frame_end = (bit_q == FRAME_LAST);

   // ***********************************************************************
   // Sequencer.
   // ***********************************************************************
   always_comb begin
      st_d = st_q;
      cnt_d = tdone ? cnt_q : cnt_q - TW'(1);
      bit_d = bit_q;
      sh_d = sh_q;
      unique case (st_q)
         ASO_POR: begin
            // The strap is read only once, so a later pin level has no effect.
            if (tdone) begin
               st_d = sck_s ? ASO_CONV : ASO_EXT;
            end
         end
         ASO_CONV: begin
            if (conv_done) begin
               st_d = ASO_SLEEP;
               sh_d = {PEND_IDLE, conv_data};
               cnt_d = HALF_LOAD;
            end
         end
         ASO_SLEEP: begin
            if (tdone) begin
               st_d = ASO_HI;
               bit_d = FRAME_FIRST;
               cnt_d = HALF_LOAD;
            end
         end
         ASO_HI: begin
            if (tdone) begin
               if (frame_end) begin
                  st_d = ASO_CONV;
               end else begin
                  st_d = ASO_LO;
                  sh_d = {sh_q[FRAME_BITS-2:0], PEND_IDLE};
                  cnt_d = HALF_LOAD;
               end
            end
         end
         ASO_LO: begin
            if (tdone) begin
               st_d = ASO_HI;
               bit_d = bit_q + 6'h01;
               cnt_d = HALF_LOAD;
            end
         end
         ASO_EXT: begin
            st_d = ASO_EXT;
         end
         default: begin
            st_d = ASO_POR;
         end
      endcase
   end

   // ***********************************************************************
   // Pin values, all registered so the pins never glitch.
   // ***********************************************************************
   wire in_conv = (st_d == ASO_CONV);
   wire clk_low = (st_d == ASO_SLEEP) || (st_d == ASO_LO);
   wire drive = (st_d != ASO_POR) && (st_d != ASO_EXT);
   wire sck_val = !clk_low;
   wire sdo_val = in_conv ? 1'b1 : (clk_low && st_d == ASO_SLEEP) ? 1'b0 : sh_d[FRAME_BITS-1];
   wire start_val = in_conv && (st_q != ASO_CONV);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= ASO_POR;
         cnt_q <= POR_LOAD;
         bit_q <= '0;
         sh_q <= '0;
         sck_q <= 1'b0;
         oe_q <= 1'b0;
         pu_q <= 1'b1;
         sdo_q <= 1'b0;
         start_q <= 1'b0;
         pend_q <= 1'b0;
         ext_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         sck_q <= sck_val;
         oe_q <= drive;
         pu_q <= (st_d == ASO_POR);
         sdo_q <= sdo_val;
         start_q <= start_val;
         pend_q <= in_conv;
         ext_q <= (st_d == ASO_EXT);
      end
   end

   assign sck_o = sck_q;
   assign sck_oe = oe_q;
   assign sck_pu_en = pu_q;
   assign sdo_o = sdo_q;
   assign conv_start = start_q;
   assign conv_pending = pend_q;
   assign ext_mode = ext_q;

   // ***********************************************************************
   // Checks.
   // ***********************************************************************
   logic [TW-1:0] por_len_q, slp_len_q;
   logic [5:0] rises_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         por_len_q <= '0;
         slp_len_q <= '0;
         rises_q <= '0;
      end else begin
         por_len_q <= pu_q ? por_len_q + TW'(1) : por_len_q;
         slp_len_q <= (st_q == ASO_SLEEP) ? slp_len_q + TW'(1) : T_ZERO;
         rises_q <= pend_q ? 6'h00 : (sck_q && !$past(sck_q)) ? rises_q + 6'h01 : rises_q;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_por_length: assert property ($fell(sck_pu_en) |-> por_len_q == TW'(POR_CYCLES))
      else $error("power-on window has the wrong length");
   a_mode_strap: assert property ($fell(sck_pu_en) |-> conv_pending == $past(sck_s)
      && ext_mode == !$past(sck_s))
      else $error("mode does not follow the strap level");
   a_ext_quiet: assert property (ext_mode |-> !sck_oe && !conv_pending ##1 ext_mode)
      else $error("external mode drives the clock pin");
   a_conv_high: assert property (conv_pending |-> sck_o && sdo_o && sck_oe)
      else $error("clock or data low during conversion");
   a_done_low: assert property (st_q == ASO_CONV && conv_done |=> !sck_o && !sdo_o
      && !conv_pending)
      else $error("conversion end not shown on the pins");
   a_sleep_min: assert property ((st_q == ASO_SLEEP) ##1 (st_q == ASO_HI)
      |-> slp_len_q >= TW'(HALF_CYCLES))
      else $error("sleep shorter than half a clock period");
   a_frame_rises: assert property ($rose(conv_pending) && !$past(sck_pu_en)
      |-> rises_q == FRAME_LAST)
      else $error("frame did not hold 32 rising edges");
   a_data_fall: assert property (!conv_pending && !$past(conv_pending) && $changed(sdo_o)
      |-> $fell(sck_o))
      else $error("data changed away from a falling clock edge");
   a_new_conv: assert property ($rose(conv_pending) && !$past(sck_pu_en)
      |-> sdo_o && sck_o && $past(sck_o) && conv_start)
      else $error("new conversion not announced correctly");
   a_flag_sleep: assert property ($fell(conv_pending) |-> !sdo_o && !sck_o)
      else $error("pending flag not cleared on entering sleep");
   a_auto_run: assert property (st_q == ASO_CONV && conv_done |-> ##[1:1000] sck_o)
      else $error("output cycle did not start by itself");
endmodule

// [test/aso_rx_model.sv]
`timescale 1ns/1ns
// ***************************************************************************
// Far-end receiver of the two-wire link; it also resolves the clock wire.
// ***************************************************************************
module aso_rx_model (
   input wire logic sck_o,     // Device clock drive value.
   input wire logic sck_oe,    // Device clock drive enable.
   input wire logic sck_pu_en, // Device weak pull-up.
   input wire logic load_low,  // Heavy load that defeats the weak pull-up.
   input wire logic sdo,       // Data line, always driven by the device.
   input wire logic clr,       // Restarts frame capture.
   output logic sck,           // Resolved clock wire.
   output logic [31:0] word,   // Captured bits, first bit highest.
   output int cnt              // Rising clock edges since the last restart.
);
   // No chip select is modelled, so the data line comes from the device alone and the clock line from the device and load_low.
   // An undriven wire without pull-up decays low; a heavy load beats the pull-up.
   assign sck = sck_oe ? sck_o : (sck_pu_en & ~load_low);
   always @(posedge sck or posedge clr) begin
      if (clr) begin
         word = 32'h0;
         cnt = 0;
      end else begin
         word = {word[30:0], sdo};
         cnt = cnt + 1;
      end
   end
endmodule

// [test/tb_aso_serial_out.sv]
`timescale 1ns/1ns
module tb_aso_serial_out;
   import aso_pkg::*;
   localparam int HALF = 4;
   localparam int PORC = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic conv_done = 1'b0;
   logic [30:0] conv_data = 31'h0;
   logic load_low = 1'b0;
   logic clr = 1'b0;
   logic sck, sck_o, sck_oe, sck_pu_en, sdo_o, conv_start, conv_pending, ext_mode;
   logic [31:0] word;
   logic [31:0] e;
   logic [31:0] exp_q[$];
   int cnt;
   int n;
   int bad_count = 0;
   int n_checks = 0;
   always #10 clk = ~clk;
   aso_serial_out #(.POR_CYCLES(PORC), .HALF_CYCLES(HALF), .DATA_W(31)) u_aso_serial_out (
      .clk(clk), .rst_n(rst_n), .sck_i(sck), .sck_o(sck_o), .sck_oe(sck_oe),
      .sck_pu_en(sck_pu_en), .sdo_o(sdo_o), .conv_done(conv_done), .conv_data(conv_data),
      .conv_start(conv_start), .conv_pending(conv_pending), .ext_mode(ext_mode));
   aso_rx_model u_aso_rx_model (.sck_o(sck_o), .sck_oe(sck_oe), .sck_pu_en(sck_pu_en),
      .load_low(load_low), .sdo(sdo_o), .clr(clr), .sck(sck), .word(word), .cnt(cnt));
   // ************************************************************************
   // Checking and closing.
   // ************************************************************************
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] expv);
      n_checks++;
      if (seen !== expv) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", name, expv, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // A frame plus its sleep is under 300 cycles, so 400 is a safe bound.
   task automatic wait_start();
      n = 0;
      while (conv_start !== 1'b1) begin
         n++;
         if (n > 400) begin
            bad_count++;
            $display("unexpected conversion start: expected pulse, seen timeout");
            results();
         end
         @(negedge clk);
      end
   endtask
   task automatic do_reset(input logic low);
      @(negedge clk);
      rst_n = 1'b0;
      load_low = low;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
   endtask
   task automatic pulse_done(input logic [30:0] d);
      conv_done = 1'b1;
      conv_data = d;
      @(negedge clk);
      conv_done = 1'b0;
   endtask
   // A stray completion just after the first rising clock edge of the frame must not disturb the word on the wire.
   task automatic frame(input logic poke);
      logic [30:0] d;
      d = 31'($urandom());
      exp_q.push_back({PEND_IDLE, d});
      clr = 1'b1;
      pulse_done(d);
      clr = 1'b0;
      chk("sleep clock", 32'(sck), 32'h0);
      chk("sleep data", 32'(sdo_o), 32'h0);
      chk("pending in sleep", 32'(conv_pending), 32'h0);
      n = 0;
      while (sck === 1'b0 && n < 100) begin
         n++;
         @(negedge clk);
      end
      chk("sleep length", 32'(n), 32'(HALF));
      if (poke) pulse_done(~d);
      wait_start();
      e = exp_q.pop_front();
      chk("frame word", word, e);
      chk("rise count", 32'(cnt), 32'h20);
      chk("data after frame", 32'(sdo_o), 32'h1);
      chk("clock after frame", 32'(sck), 32'h1);
      chk("pending after frame", 32'(conv_pending), 32'h1);
   endtask
   initial begin
      void'($urandom(44));
      do_reset(1'b0);
      chk("pull-up in por", 32'(sck_pu_en), 32'h1);
      wait_start();
      chk("mode", 32'(ext_mode), 32'h0);
      chk("pull-up after por", 32'(sck_pu_en), 32'h0);
      repeat (5) @(negedge clk);
      chk("conv clock", 32'(sck), 32'h1);
      chk("conv data", 32'(sdo_o), 32'h1);
      chk("pending", 32'(conv_pending), 32'h1);
      chk("start pulse length", 32'(conv_start), 32'h0);
      $display("test self-clocked start done");
      for (int i = 0; i < 4; i++) begin
         frame(i[0]);
      end
      $display("test frames done");
      do_reset(1'b1);
      repeat (PORC + 4) @(negedge clk);
      chk("mode", 32'(ext_mode), 32'h1);
      chk("clock drive", 32'(sck_oe), 32'h0);
      pulse_done(31'h1);
      repeat (3) @(negedge clk);
      chk("pending in ext", 32'(conv_pending), 32'h0);
      $display("test external mode done");
      results();
   end
endmodule
